//--- asc_serial_ctrl.v
// Control, ninth-bit and status-flag logic of an asynchronous serial interface.
// Assumes a CPU on the plain register port and a remote node on the serial pins.
`timescale 1ns/1ns
`include "asc_defines.vh"

// Contract
// [RULE_01] Receive-full interrupts only when its enable set.
// [RULE_02] Idle interrupts only when idle enable set.
// [RULE_03] Enabling transmitter sends a preamble of ones.
// [RULE_04] Disabling transmitter finishes current character first.
// [RULE_05] Off-then-on during character queues idle character.
// [RULE_06] Enable writes ignored while module is off.
// [RULE_07] Receiver disable leaves receive flags unchanged.
// [RULE_08] Standby mutes receive interrupts until wake condition.
// [RULE_09] Break control sends breaks, then one bit.
// [RULE_10] Early break toggle replaces the preamble.
// [RULE_11] Received ninth bit captured with data buffer.
// [RULE_12] Transmit ninth bit loaded with data.
// [RULE_13] Error flags interrupt only through own enables.
// [RULE_14] Transmit-empty sets on load, clears status-then-write.
// [RULE_15] Transmit-empty interrupts when its enable set.
// [RULE_16] Transmit-done sets when nothing sent or queued.
// [RULE_17] Receive-full sets on transfer, clears status-then-read.
// [RULE_18] Idle flag sets after ten or eleven ones.
// [RULE_19] Idle needs a received character before setting.
// [RULE_20] Overrun discards new character, keeps buffer.
// [RULE_21] Overrun clears only if seen at status read.
// [RULE_22] Noise flag sets on noise, clears status-then-read.
// [RULE_23] Module off forces transmit flags set, mutes interrupts; only tx_irq_o is muted here.
// [RULE_24] Enabled receive errors merge into one request.
module asc_serial_ctrl #(
	parameter BIT_CYCLES = `ASC_BIT_CYCLES
) (
	input wire ref_clk_i, // Module clock, 100 MHz.
	input wire rst_n_i, // Asynchronous reset, active low.
	input wire [2:0] addr_i, // Register address.
	input wire [7:0] wdata_i, // Write data.
	input wire wr_i, // Write strobe, one cycle.
	input wire rd_i, // Read strobe, one cycle.
	output reg [7:0] rdata_o, // Read data, valid the cycle after rd_i.
	input wire rxd_i, // Serial receive pin.
	output wire txd_o, // Serial transmit pin, idle high.
	output wire tx_irq_o, // Transmitter interrupt request.
	output wire rx_irq_o, // Receiver interrupt request.
	output wire err_irq_o // Receive error interrupt request.
);

	// ==========================================================
	// Frame length in bits for the current character size.
	function [3:0] frame_len;
		input char9;
		begin
			frame_len = char9 ? `ASC_LEN_9 : `ASC_LEN_8;
		end
	endfunction

	// ==========================================================
	// Software-visible control state.
	reg module_on_q, char9_q, wake_addr_q; // Control register one.
	reg tx_empty_irq_en_q, tx_done_irq_en_q, rx_full_irq_en_q, idle_irq_en_q;
	reg tx_on_q, rx_on_q, rx_standby_q, send_break_ctl_q;
	reg tx_ninth_bit_q, overrun_irq_en_q, noise_irq_en_q, framing_irq_en_q, parity_irq_en_q;
	reg rx_ninth_bit_q; // Not reset: holds whatever the last character left.
	reg [7:0] tx_buf_q; // Transmit half of the data buffer, not reset.
	reg [7:0] rx_buf_q; // Receive half of the data buffer, not reset.

	// Status flags.
	reg tx_empty_flag_q, tx_done_flag_q, rx_full_flag_q, idle_flag_q;
	reg overrun_flag_q, noise_flag_q, framing_flag_q;
	wire parity_flag = 1'b0; // No parity checker here, so this flag never sets.

	// Snapshots taken at a status read for the two-step clears.
	reg snap_te_q, snap_rf_q, snap_il_q, snap_or_q, snap_nf_q, snap_fe_q;

	// Decoded accesses.
	wire wr_c1 = wr_i && (addr_i == `ASC_OFS_CTL1);
	wire wr_c2 = wr_i && (addr_i == `ASC_OFS_CTL2);
	wire wr_c3 = wr_i && (addr_i == `ASC_OFS_CTL3);
	wire wr_dat = wr_i && (addr_i == `ASC_OFS_DATA);
	wire rd_st = rd_i && (addr_i == `ASC_OFS_STAT);
	wire rd_dat = rd_i && (addr_i == `ASC_OFS_DATA);

	// ==========================================================
	// Bit-time divider, shared by both directions; halted while the module is off.
	reg [15:0] div_q;
	wire tick = module_on_q && (div_q == (BIT_CYCLES - 1));
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			div_q <= 16'h0000;
		else if (!module_on_q || tick)
			div_q <= 16'h0000;
		else
			div_q <= div_q + 16'h0001;
	end

	// ==========================================================
	// Control registers. Enables for the shifters only move while the module is on.
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			module_on_q <= 1'b0;
			char9_q <= 1'b0;
			wake_addr_q <= 1'b0;
			tx_empty_irq_en_q <= 1'b0;
			tx_done_irq_en_q <= 1'b0;
			rx_full_irq_en_q <= 1'b0; // RULE_01
			idle_irq_en_q <= 1'b0; // RULE_02
			tx_on_q <= 1'b0; // RULE_04
			rx_on_q <= 1'b0; // RULE_07
			send_break_ctl_q <= 1'b0;
			tx_ninth_bit_q <= 1'b0; // RULE_12
			overrun_irq_en_q <= 1'b0; // RULE_13
			noise_irq_en_q <= 1'b0;
			framing_irq_en_q <= 1'b0;
			parity_irq_en_q <= 1'b0;
		end else begin
			if (wr_c1) begin
				module_on_q <= wdata_i[`ASC_C1_MODULE_ON];
				char9_q <= wdata_i[`ASC_C1_CHAR9];
				wake_addr_q <= wdata_i[`ASC_C1_WAKE_ADDR];
			end
			if (wr_c2) begin
				tx_empty_irq_en_q <= wdata_i[`ASC_C2_TE_IE];
				tx_done_irq_en_q <= wdata_i[`ASC_C2_TC_IE];
				rx_full_irq_en_q <= wdata_i[`ASC_C2_RF_IE];
				idle_irq_en_q <= wdata_i[`ASC_C2_IL_IE];
				send_break_ctl_q <= wdata_i[`ASC_C2_BREAK];
				if (module_on_q) begin
					// Enable writes are dropped while the module is off.
					tx_on_q <= wdata_i[`ASC_C2_TX_ON]; // RULE_06
					rx_on_q <= wdata_i[`ASC_C2_RX_ON]; // RULE_06
				end
			end
			if (wr_c3) begin
				tx_ninth_bit_q <= wdata_i[`ASC_C3_TX8];
				overrun_irq_en_q <= wdata_i[`ASC_C3_OR_IE];
				noise_irq_en_q <= wdata_i[`ASC_C3_NF_IE];
				framing_irq_en_q <= wdata_i[`ASC_C3_FE_IE];
				parity_irq_en_q <= wdata_i[`ASC_C3_PE_IE];
			end
		end
	end

	// ==========================================================
	// Transmit data buffer has no reset, as the buffer keeps its contents.
	always @(posedge ref_clk_i) begin
		if (wr_dat)
			tx_buf_q <= wdata_i;
	end

	// ==========================================================
	// Transmit sequencing: decides which frame the shifter sends next.
	reg tx_on_d1_q, brk_d1_q; // Previous values for edge detection.
	reg pre_req_q; // Preamble or idle character waiting.
	reg brk_pend_q; // Break toggled on and not yet served by a break frame.
	reg brk_tail_q; // Break just sent; a single one bit is owed.
	wire tx_busy;
	wire can_start = tick && !tx_busy && module_on_q;
	wire brk_now = send_break_ctl_q || brk_pend_q;
	wire data_ready = tx_on_q && !tx_empty_flag_q;
	reg load;
	reg [`ASC_FRAME_W-1:0] load_bits;
	reg [3:0] load_len;
	reg start_data, start_brk, start_pre, start_tail;

	// Frame choice: break first, then the owed one bit, preamble, and data last.
	always @* begin
		start_brk = 1'b0;
		start_tail = 1'b0;
		start_pre = 1'b0;
		start_data = 1'b0;
		load_bits = `ASC_ONES11;
		load_len = frame_len(char9_q);
		if (can_start && tx_on_q) begin
			if (brk_now) begin
				// An early break also takes the preamble's place.
				start_brk = 1'b1; // RULE_09 RULE_10
				load_bits = `ASC_ZERO11;
			end else if (brk_tail_q) begin
				start_tail = 1'b1; // RULE_09
				load_len = `ASC_LEN_ONE;
			end else if (pre_req_q) begin
				start_pre = 1'b1; // RULE_03 RULE_05
			end else if (data_ready) begin
				start_data = 1'b1;
				// Start, eight data bits, ninth bit when selected, then stop.
				if (char9_q)
					load_bits = {1'b1, tx_ninth_bit_q, tx_buf_q, 1'b0}; // RULE_12
				else
					load_bits = {2'b11, tx_buf_q, 1'b0};
			end
		end
		load = start_brk || start_tail || start_pre || start_data;
	end

	// Request bookkeeping. Nothing new starts once the transmitter is off,
	// but the shifter completes the frame it holds unless the module is turned off.
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_on_d1_q <= 1'b0;
			brk_d1_q <= 1'b0;
			pre_req_q <= 1'b0;
			brk_pend_q <= 1'b0;
			brk_tail_q <= 1'b0;
		end else begin
			tx_on_d1_q <= tx_on_q;
			brk_d1_q <= send_break_ctl_q;
			if (tx_on_q && !tx_on_d1_q)
				pre_req_q <= 1'b1; // RULE_03 RULE_05
			else if (start_pre || start_brk || !tx_on_q)
				pre_req_q <= 1'b0; // RULE_04
			// A toggle served by a break starting now must not queue a second one.
			if (send_break_ctl_q && !brk_d1_q && !start_brk)
				brk_pend_q <= 1'b1;
			else if (start_brk || !tx_on_q)
				brk_pend_q <= 1'b0;
			if (start_brk)
				brk_tail_q <= !send_break_ctl_q;
			else if (start_tail || !tx_on_q)
				brk_tail_q <= 1'b0;
			else if (brk_d1_q && !send_break_ctl_q && tx_busy)
				brk_tail_q <= 1'b1; // RULE_09
		end
	end

	asc_tx_shifter #(
		.W(`ASC_FRAME_W)
	) u_tx (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick),
		.load_i(load),
		.bits_i(load_bits),
		.len_i(load_len),
		.busy_o(tx_busy),
		.txd_o(txd_o)
	);

	// ==========================================================
	// Transmit flags. Turning the module off forces both flags set.
	wire tx_queued = tx_on_q && (pre_req_q || brk_now || brk_tail_q || !tx_empty_flag_q);
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_empty_flag_q <= 1'b1; // RULE_14
			tx_done_flag_q <= 1'b1; // RULE_16
			snap_te_q <= 1'b0;
		end else if (!module_on_q) begin
			tx_empty_flag_q <= 1'b1; // RULE_23
			tx_done_flag_q <= 1'b1; // RULE_23
			snap_te_q <= 1'b0;
		end else begin
			if (rd_st)
				snap_te_q <= tx_empty_flag_q;
			else if (wr_dat)
				snap_te_q <= 1'b0;
			if (start_data)
				tx_empty_flag_q <= 1'b1; // RULE_14
			else if (wr_dat && snap_te_q)
				tx_empty_flag_q <= 1'b0; // RULE_14
			// Done only when idle with nothing queued; clears as soon as work waits.
			tx_done_flag_q <= tx_empty_flag_q && !tx_busy && !load && !tx_queued; // RULE_16
		end
	end

	// ==========================================================
	// Receive pin synchroniser; only the second stage feeds logic.
	reg rxd_s1_q, rxd_s2_q;
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
		end else begin
			rxd_s1_q <= rxd_i;
			rxd_s2_q <= rxd_s1_q;
		end
	end

	// ==========================================================
	// Receiver. Three samples around mid-bit give a majority vote and a noise hint.
	localparam RX_IDLE = 1'b0;
	localparam RX_BITS = 1'b1;
	localparam integer MID = BIT_CYCLES / 2;
	wire rx_run = module_on_q && rx_on_q;
	reg rx_st_q;
	reg [15:0] rcnt_q;
	reg [3:0] rbit_q; // Bits of the frame taken so far, start bit included.
	reg [9:0] rsh_q; // Data, ninth bit and stop bit, filled MSB first.
	reg [2:0] smp_q;
	reg rnoise_q;
	reg [3:0] ones_q; // Whole bit times of high line seen while idle.
	reg rx_on_d1_q, idle_arm_q;
	wire vote = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]);
	wire bit_end = (rx_st_q == RX_BITS) && (rcnt_q == MID + 16'h0001);
	wire frame_end = bit_end && (rbit_q == frame_len(char9_q) - 4'h1);
	wire [8:0] rdata = char9_q ? rsh_q[9:1] : {1'b0, rsh_q[9:2]};
	wire stop_ok = vote;
	wire addr_mark = char9_q ? rdata[8] : rdata[7];
	wire accept = frame_end && !(rx_standby_q && !(wake_addr_q && addr_mark));
	wire load_buf = accept && !rx_full_flag_q;
	wire idle_hit = (rx_st_q == RX_IDLE) && tick && rxd_s2_q && (ones_q == frame_len(char9_q) - 4'h1);

	// Receive shifting and line idle counting.
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_st_q <= RX_IDLE;
			rcnt_q <= 16'h0000;
			rbit_q <= 4'h0;
			rsh_q <= 10'h000;
			smp_q <= 3'h7;
			rnoise_q <= 1'b0;
			ones_q <= 4'h0;
		end else if (!rx_run) begin
			rx_st_q <= RX_IDLE; // RULE_07
			ones_q <= 4'h0;
		end else begin
			case (rx_st_q)
				RX_IDLE: begin
					if (!rxd_s2_q) begin
						rx_st_q <= RX_BITS;
						rcnt_q <= 16'h0000;
						rbit_q <= 4'h0;
						rnoise_q <= 1'b0;
						ones_q <= 4'h0;
					end else if (tick && ones_q != 4'hf) begin
						ones_q <= ones_q + 4'h1; // RULE_18
					end
				end
				RX_BITS: begin
					rcnt_q <= (rcnt_q == BIT_CYCLES - 1) ? 16'h0000 : rcnt_q + 16'h0001;
					// All three votes must land before the decision at MID+1.
					if (rcnt_q >= MID - 16'h0002 && rcnt_q <= MID)
						smp_q <= {smp_q[1:0], rxd_s2_q};
					if (rcnt_q == MID + 16'h0001) begin
						if (smp_q[0] != smp_q[1] || smp_q[1] != smp_q[2])
							rnoise_q <= 1'b1;
						if (rbit_q == 4'h0 && vote)
							rx_st_q <= RX_IDLE; // False start bit.
						else if (frame_end)
							rx_st_q <= RX_IDLE;
						if (rbit_q != 4'h0)
							rsh_q <= {vote, rsh_q[9:1]};
						rbit_q <= rbit_q + 4'h1;
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// Receive data buffer and ninth bit carry no reset.
	always @(posedge ref_clk_i) begin
		if (load_buf) begin
			rx_buf_q <= rdata[7:0]; // RULE_20
			rx_ninth_bit_q <= char9_q ? rdata[8] : rdata[7]; // RULE_11
		end
	end

	// ==========================================================
	// Receive flags and standby. For the flags, a setting event wins over a same-cycle clear.
	wire clr = rd_dat;
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_full_flag_q <= 1'b0; // RULE_17
			idle_flag_q <= 1'b0; // RULE_18
			overrun_flag_q <= 1'b0; // RULE_20
			noise_flag_q <= 1'b0; // RULE_22
			framing_flag_q <= 1'b0;
			rx_standby_q <= 1'b0; // RULE_08
			snap_rf_q <= 1'b0;
			snap_il_q <= 1'b0;
			snap_or_q <= 1'b0;
			snap_nf_q <= 1'b0;
			snap_fe_q <= 1'b0;
			rx_on_d1_q <= 1'b0;
			idle_arm_q <= 1'b0;
		end else begin
			rx_on_d1_q <= rx_run;
			if (rd_st) begin
				snap_rf_q <= rx_full_flag_q;
				snap_il_q <= idle_flag_q;
				snap_or_q <= overrun_flag_q; // RULE_21
				snap_nf_q <= noise_flag_q;
				snap_fe_q <= framing_flag_q;
			end else if (clr) begin
				{snap_rf_q, snap_il_q, snap_or_q, snap_nf_q, snap_fe_q} <= 5'h00;
			end
			if (load_buf)
				rx_full_flag_q <= 1'b1; // RULE_17
			else if (clr && snap_rf_q)
				rx_full_flag_q <= 1'b0; // RULE_17
			if (accept && rx_full_flag_q)
				overrun_flag_q <= 1'b1; // RULE_20
			else if (clr && snap_or_q)
				overrun_flag_q <= 1'b0; // RULE_21
			if (load_buf && rnoise_q)
				noise_flag_q <= 1'b1; // RULE_22
			else if (clr && snap_nf_q)
				noise_flag_q <= 1'b0; // RULE_22
			if (load_buf && !stop_ok)
				framing_flag_q <= 1'b1;
			else if (clr && snap_fe_q)
				framing_flag_q <= 1'b0;
			// Idle may only set once a character has arrived since enable or since the idle flag last set.
			if (rx_run && !rx_on_d1_q)
				idle_arm_q <= 1'b0; // RULE_19
			else if (load_buf)
				idle_arm_q <= 1'b1; // RULE_19
			else if (idle_hit && !rx_standby_q)
				idle_arm_q <= 1'b0; // RULE_19
			if (idle_hit && idle_arm_q && !rx_standby_q)
				idle_flag_q <= 1'b1; // RULE_18
			else if (clr && snap_il_q)
				idle_flag_q <= 1'b0; // RULE_18
			// Wake condition ends standby ahead of a software write.
			if ((wake_addr_q && frame_end && addr_mark) || (!wake_addr_q && idle_hit))
				rx_standby_q <= 1'b0; // RULE_08
			else if (wr_c2)
				rx_standby_q <= wdata_i[`ASC_C2_STANDBY];
		end
	end

	// ==========================================================
	// Interrupt requests, levels straight from flags and enables.
	assign tx_irq_o = module_on_q && ((tx_empty_flag_q && tx_empty_irq_en_q) ||
		(tx_done_flag_q && tx_done_irq_en_q)); // RULE_15 RULE_16 RULE_23
	assign rx_irq_o = !rx_standby_q && ((rx_full_flag_q && rx_full_irq_en_q) ||
		(idle_flag_q && idle_irq_en_q)); // RULE_01 RULE_02 RULE_08
	assign err_irq_o = (overrun_flag_q && overrun_irq_en_q) ||
		(noise_flag_q && noise_irq_en_q) || (framing_flag_q && framing_irq_en_q) ||
		(parity_flag && parity_irq_en_q); // RULE_13 RULE_24

	// ==========================================================
	// Read data, registered one cycle after the strobe; unmapped reads give zero.
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= `ASC_ZERO8;
		end else if (rd_i) begin
			case (addr_i)
				`ASC_OFS_CTL1: rdata_o <= {5'h00, wake_addr_q, char9_q, module_on_q};
				`ASC_OFS_CTL2: rdata_o <= {tx_empty_irq_en_q, tx_done_irq_en_q,
					rx_full_irq_en_q, idle_irq_en_q, tx_on_q, rx_on_q, rx_standby_q,
					send_break_ctl_q};
				`ASC_OFS_CTL3: rdata_o <= {rx_ninth_bit_q, tx_ninth_bit_q, 2'b00,
					overrun_irq_en_q, noise_irq_en_q, framing_irq_en_q, parity_irq_en_q};
				`ASC_OFS_STAT: rdata_o <= {tx_empty_flag_q, tx_done_flag_q, rx_full_flag_q,
					idle_flag_q, overrun_flag_q, noise_flag_q, framing_flag_q, parity_flag};
				`ASC_OFS_DATA: rdata_o <= rx_buf_q;
				default: rdata_o <= `ASC_ZERO8;
			endcase
		end else begin
			rdata_o <= `ASC_ZERO8;
		end
	end

endmodule

//--- asc_defines.vh
// Constants for the asynchronous serial control and status block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH

// ==========================================================
// Register offsets on the plain register port.
`define ASC_OFS_CTL1 3'h0
`define ASC_OFS_CTL2 3'h1
`define ASC_OFS_CTL3 3'h2
`define ASC_OFS_STAT 3'h3
`define ASC_OFS_DATA 3'h4

// ==========================================================
// Control register one bit positions.
`define ASC_C1_MODULE_ON 0
`define ASC_C1_CHAR9 1
`define ASC_C1_WAKE_ADDR 2

// ==========================================================
// Control register two bit positions.
`define ASC_C2_TE_IE 7
`define ASC_C2_TC_IE 6
`define ASC_C2_RF_IE 5
`define ASC_C2_IL_IE 4
`define ASC_C2_TX_ON 3
`define ASC_C2_RX_ON 2
`define ASC_C2_STANDBY 1
`define ASC_C2_BREAK 0

// ==========================================================
// Control register three bit positions.
`define ASC_C3_RX8 7
`define ASC_C3_TX8 6
`define ASC_C3_OR_IE 3
`define ASC_C3_NF_IE 2
`define ASC_C3_FE_IE 1
`define ASC_C3_PE_IE 0

// ==========================================================
// Frame lengths in bit times and shifter widths.
`define ASC_LEN_8 4'h0a
`define ASC_LEN_9 4'h0b
`define ASC_LEN_ONE 4'h1
`define ASC_FRAME_W 11
`define ASC_ZERO8 8'h00
`define ASC_ONES11 11'h7ff
`define ASC_ZERO11 11'h000
`define ASC_BIT_CYCLES 16

`endif

//--- asc_tx_shifter.v
// Transmit shift register that sends one frame of up to eleven bits, LSB first.
// Assumes a one-cycle bit tick from the parent and a load only while not busy.
`timescale 1ns/1ns
`include "asc_defines.vh"

module asc_tx_shifter #(
	parameter W = `ASC_FRAME_W
) (
	input wire ref_clk_i, // Module clock.
	input wire rst_n_i, // Asynchronous reset, active low.
	input wire tick_i, // One pulse per bit time.
	input wire load_i, // Load a new frame; honoured only while idle.
	input wire [W-1:0] bits_i, // Frame bits, first bit in bit 0.
	input wire [3:0] len_i, // Number of bits in the frame.
	output wire busy_o, // A frame is being shifted out.
	output reg txd_o // Serial output, idle high.
);

	// ==========================================================
	// Shifter state.
	reg [W-1:0] sh_q; // Bits still to be sent.
	reg [3:0] left_q; // Bits remaining in the frame.

	// The last bit stays busy up to its closing tick, so done never rises mid stop bit.
	assign busy_o = (left_q > 4'h1) || (left_q == 4'h1 && !tick_i);

	// ==========================================================
	// The line changes only on a tick so every bit lasts one full bit time.
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sh_q <= `ASC_ONES11;
			left_q <= 4'h0;
			txd_o <= 1'b1;
		end else if (tick_i) begin
			if (left_q > 4'h1) begin
				// Shift the next bit out.
				txd_o <= sh_q[0];
				sh_q <= {1'b1, sh_q[W-1:1]};
				left_q <= left_q - 4'h1;
			end else if (load_i) begin
				// First bit goes out on the same tick as the load.
				txd_o <= bits_i[0];
				sh_q <= {1'b1, bits_i[W-1:1]};
				left_q <= len_i;
			end else begin
				// Nothing queued: the line rests high.
				txd_o <= 1'b1;
				left_q <= 4'h0;
			end
		end
	end

endmodule

//--- asc_serial_ctrl_properties.sv
// Checker for the serial control block: port relations only.
// Assumes it is bound to every instance of asc_serial_ctrl.
`timescale 1ns/1ns
`include "asc_defines.vh"
module asc_serial_ctrl_properties #(
	parameter BIT_CYCLES = 16
) (
	input wire ref_clk_i, // Clock.
	input wire rst_n_i, // Reset, active low.
	input wire [2:0] addr_i, // Address.
	input wire [7:0] wdata_i, // Write data.
	input wire wr_i, // Write strobe.
	input wire rd_i, // Read strobe.
	input wire [7:0] rdata_o, // Read data.
	input wire rxd_i, // Receive pin.
	input wire txd_o, // Transmit pin.
	input wire tx_irq_o, // Transmit request.
	input wire rx_irq_o, // Receive request.
	input wire err_irq_o // Error request.
);
	// ==========================================================
	// Shadow of the enables; a request without its enable is a fault.
	reg wrote_q, mod_q, ever_q, tx_en_q, rx_en_q, err_en_q;
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{wrote_q, mod_q, ever_q, tx_en_q, rx_en_q, err_en_q} <= 6'h00;
		end else if (wr_i) begin
			wrote_q <= 1'b1;
			if (addr_i == `ASC_OFS_CTL1) begin
				mod_q <= wdata_i[`ASC_C1_MODULE_ON];
				ever_q <= ever_q | wdata_i[`ASC_C1_MODULE_ON];
			end
			if (addr_i == `ASC_OFS_CTL2) begin
				tx_en_q <= |wdata_i[7:6];
				rx_en_q <= |wdata_i[5:4];
			end
			if (addr_i == `ASC_OFS_CTL3) begin
				err_en_q <= |wdata_i[3:0];
			end
		end
	end
	// ==========================================================
	// Assertions, all in the one clock domain.
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	AST_QUIET: assert property (!wrote_q |-> !(tx_irq_o | rx_irq_o | err_irq_o))
		else $error("request before any write");
	AST_RESET_STATUS: assert property ($past(rd_i && addr_i == `ASC_OFS_STAT) && !wrote_q |-> rdata_o == 8'hc0)
		else $error("status after reset wrong");
	AST_OFF_STATUS: assert property ($past(rd_i && addr_i == `ASC_OFS_STAT && !mod_q) && !$past(mod_q, 2) |-> rdata_o[7:6] == 2'h3)
		else $error("transmit flags not forced");
	AST_OFF_TX_IRQ: assert property (!mod_q |-> !tx_irq_o)
		else $error("transmit request while off");
	AST_TX_IRQ: assert property ($rose(tx_irq_o) |-> tx_en_q && mod_q)
		else $error("transmit request without enable");
	AST_RX_IRQ: assert property (rx_irq_o |-> rx_en_q)
		else $error("receive request without enable");
	AST_ERR_IRQ: assert property (err_irq_o |-> err_en_q)
		else $error("error request without enable");
	AST_TX_LOCKED: assert property (!ever_q |-> txd_o)
		else $error("line moved with module never on");
endmodule

bind asc_serial_ctrl asc_serial_ctrl_properties #(.BIT_CYCLES(BIT_CYCLES)) u_props (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o),
	.tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));

//--- asc_remote_node.sv
// Remote serial node: sends frames on its line and captures frames.
// Assumes BIT clock cycles a bit, LSB first, line idle high.
`timescale 1ns/1ns
module asc_remote_node #(
	parameter BIT = 8
) (
	input wire ref_clk_i, // Shared clock.
	input wire txd_i, // Line from the block.
	output reg rxd_o // Line into the block.
);
	// The line rests high between frames, so idle follows each frame.
	initial rxd_o = 1'b1;
	// Start, n data bits, stop; a one-cycle glitch in bit 0 if asked.
	task send(input [8:0] d, input integer n, input noisy);
		integer i, j;
		begin
			for (i = 0; i < n + 2; i++) begin
				for (j = 0; j < BIT; j++) begin
					@(posedge ref_clk_i);
					rxd_o <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : d[i-1] ^ (noisy && i == 1 && j == BIT / 2);
				end
			end
		end
	endtask
	// Waits for a start bit, then samples n data bits and the stop bit mid-bit.
	task capture(input integer n, output [9:0] d, output integer w);
		integer i;
		begin
			w = 0;
			d = 10'h000;
			while (txd_i === 1'b1 && w < 400) begin
				@(posedge ref_clk_i);
				w++;
			end
			repeat (BIT / 2) @(posedge ref_clk_i);
			for (i = 0; i <= n; i++) begin
				repeat (BIT) @(posedge ref_clk_i);
				d[i] = txd_i;
			end
		end
	endtask
endmodule

//--- asc_serial_ctrl_test.sv
// Self-checking bench for the serial control block.
// Assumes the remote node model and the bound checker are compiled.
`timescale 1ns/1ns
`include "asc_defines.vh"
module asc_serial_ctrl_test;
	localparam B = 8;
	reg ref_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	reg [2:0] addr_i = 3'h0;
	reg [7:0] wdata_i = 8'h00, r;
	reg [9:0] f;
	wire [7:0] rdata_o;
	wire rxd, txd_o, tx_irq_o, rx_irq_o, err_irq_o;
	integer bad_count = 0, checks = 0, w;
	`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
	always #5 ref_clk_i = ~ref_clk_i;
	asc_serial_ctrl #(.BIT_CYCLES(B)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.rxd_i(rxd), .txd_o(txd_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));
	asc_remote_node #(.BIT(B)) node (.ref_clk_i(ref_clk_i), .txd_i(txd_o), .rxd_o(rxd));
	// One-cycle bus strobes; read data is taken in the cycle after the strobe.
	task wr(input [2:0] a, input [7:0] d);
		begin
			@(posedge ref_clk_i);
			addr_i <= a;
			wdata_i <= d;
			wr_i <= 1'b1;
			@(posedge ref_clk_i);
			wr_i <= 1'b0;
			#1;
		end
	endtask
	task rd(input [2:0] a);
		begin
			@(posedge ref_clk_i);
			addr_i <= a;
			rd_i <= 1'b1;
			@(posedge ref_clk_i);
			rd_i <= 1'b0;
			#1 r = rdata_o;
		end
	endtask
	task stop_test;
		begin
			if (bad_count == 0 && checks > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	// Reset values, then enables refused while the module is off.
	task t_reset_lock;
		begin
			rd(`ASC_OFS_STAT); `CHK("stat", 8'hc0, r)
			rd(`ASC_OFS_CTL3); `CHK("ctl3", 7'h00, r[6:0])
			wr(`ASC_OFS_CTL2, 8'hcc); rd(`ASC_OFS_CTL2); `CHK("ctl2", 8'hc0, r)
			`CHK("txirq", 1'b0, tx_irq_o)
			wr(`ASC_OFS_CTL1, 8'h01); `CHK("txirq", 1'b1, tx_irq_o)
		end
	endtask
	// Preamble, an 8-bit frame, then a 9-bit frame with its ninth bit.
	task t_tx;
		begin
			wr(`ASC_OFS_CTL2, 8'h08); rd(`ASC_OFS_STAT); wr(`ASC_OFS_DATA, 8'ha5);
			rd(`ASC_OFS_STAT); `CHK("txflags", 2'h0, r[7:6])
			node.capture(8, f, w); `CHK("frame", 10'h1a5, f[9:0])
			`CHK("preamble", 1'b1, w >= 10 * B - 6 && w <= 12 * B)
			repeat (2 * B) @(posedge ref_clk_i);
			rd(`ASC_OFS_STAT); `CHK("stat", 8'hc0, r)
			wr(`ASC_OFS_CTL1, 8'h03); wr(`ASC_OFS_CTL3, 8'h40); rd(`ASC_OFS_STAT);
			wr(`ASC_OFS_DATA, 8'h3c); node.capture(9, f, w); `CHK("frame9", 10'h33c, f)
			wr(`ASC_OFS_CTL2, 8'h09); wr(`ASC_OFS_CTL2, 8'h08);
			node.capture(8, f, w); `CHK("break", 10'h000, f)
			repeat (2 * B) @(posedge ref_clk_i);
			wr(`ASC_OFS_CTL1, 8'h01);
		end
	endtask
	// Receive, idle after a character only, two-step clears.
	task t_rx;
		begin
			wr(`ASC_OFS_CTL2, 8'h26); repeat (12 * B) @(posedge ref_clk_i);
			rd(`ASC_OFS_STAT); `CHK("idle", 1'b0, r[4])
			rd(`ASC_OFS_CTL2); `CHK("wake", 8'h24, r)
			node.send(9'h0a5, 8, 1'b0); repeat (12 * B) @(posedge ref_clk_i);
			`CHK("rxirq", 1'b1, rx_irq_o)
			rd(`ASC_OFS_STAT); `CHK("stat", 8'hf0, r)
			rd(`ASC_OFS_DATA); `CHK("data", 8'ha5, r)
			rd(`ASC_OFS_CTL3); `CHK("rx8", 1'b1, r[7])
			rd(`ASC_OFS_STAT); `CHK("stat", 8'hc0, r)
		end
	endtask
	// Overrun, receiver off keeps flags, noise flag and error request.
	task t_err;
		begin
			wr(`ASC_OFS_CTL3, 8'h0c); node.send(9'h011, 8, 1'b0); node.send(9'h022, 8, 1'b0);
			repeat (2 * B) @(posedge ref_clk_i);
			`CHK("errirq", 1'b1, err_irq_o)
			wr(`ASC_OFS_CTL2, 8'h00); rd(`ASC_OFS_DATA); `CHK("data", 8'h11, r)
			rd(`ASC_OFS_STAT); `CHK("keep", 2'h3, {r[5], r[3]})
			rd(`ASC_OFS_DATA); `CHK("data", 8'h11, r)
			rd(`ASC_OFS_STAT); `CHK("clr", 2'h0, {r[5], r[3]})
			wr(`ASC_OFS_CTL2, 8'h04); node.send(9'h033, 8, 1'b1);
			repeat (2 * B) @(posedge ref_clk_i);
			rd(`ASC_OFS_STAT); `CHK("noise", 1'b1, r[2])
			`CHK("errirq", 1'b1, err_irq_o)
			rd(`ASC_OFS_DATA); rd(`ASC_OFS_STAT); `CHK("noise", 1'b0, r[2])
		end
	endtask
	initial begin
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		t_reset_lock;
		t_tx;
		t_rx;
		t_err;
		stop_test;
	end
	// Hang guard, well beyond the thousand or so cycles the run needs.
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		bad_count++;
		stop_test;
	end
endmodule
